// ---- timer_params.svh ----
// Offsets, field positions, reset values and widths of the timer block.
// Assumes a byte-addressed APB space with one 32-bit word per register.
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// Register byte offsets
`define OFS_T0_CTRL 8'h00
`define OFS_T0_COUNT 8'h04
`define OFS_T1_CTRL_B 8'h08
`define OFS_PLL_CS 8'h0C
`define OFS_FLAGS 8'h10
`define OFS_MASK 8'h14

// Field positions
`define T0_CLR_BIT 3
`define T1_CLR_BIT 6
`define PLL_FAST_BIT 2
`define FLAG_T0_OVF_BIT 0

// Widths and values
`define T0_PRE_W 10
`define T1_PRE_W 14
`define BYTE_RESET 8'h00
`define T0_COUNT_MAX 8'hFF

`endif

// ---- timer_pkg.sv ----
// Types shared by the timer prescalers and the first timer.
// Assumes timer_params.svh supplies the numeric constants.
package timer_pkg;

  // First timer count source select
  typedef enum logic [2:0] {
    CS0_STOP = 3'h0, CS0_DIV1 = 3'h1, CS0_DIV8 = 3'h2, CS0_DIV64 = 3'h3,
    CS0_DIV256 = 3'h4, CS0_DIV1024 = 3'h5, CS0_EXT_FALL = 3'h6, CS0_EXT_RISE = 3'h7
  } t0_src_t;

  // APB slave phase
  typedef enum logic [1:0] {APB_IDLE = 2'b01, APB_ACCESS = 2'b10} apb_state_t;

endpackage

// ---- presc_if.sv ----
// Link between the timer control logic and one prescaler.
// Assumes both ends run on the same clock and reset.
interface presc_if;
  logic clear;
  logic src_tick;
  logic [3:0] sel;
  logic tick;

  // Control side drives select, clear and source; prescaler returns tick
  modport ctrl (output clear, output src_tick, output sel, input tick);
  modport presc (input clear, input src_tick, input sel, output tick);
endinterface

// ---- t0_prescaler.sv ----
// Divider for the first timer: taps at 1, 8, 64, 256 and 1024.
// Assumes src_tick marks one source clock step per pclk cycle at most.
`include "timer_params.svh"
module t0_prescaler
  import timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  presc_if.presc pif
);
  logic [`T0_PRE_W-1:0] cnt_q;
  logic tap_d;

  // Free-running divider, restarted by a prescaler clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (pif.clear) begin
      cnt_q <= '0;
    end else if (pif.src_tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Tap select; codes 6 and 7 are the pin and handled outside
  always_comb begin
    case (pif.sel[2:0])
      CS0_DIV1: tap_d = pif.src_tick;
      CS0_DIV8: tap_d = pif.src_tick && (&cnt_q[2:0]);
      CS0_DIV64: tap_d = pif.src_tick && (&cnt_q[5:0]);
      CS0_DIV256: tap_d = pif.src_tick && (&cnt_q[7:0]);
      CS0_DIV1024: tap_d = pif.src_tick && (&cnt_q[9:0]);
      default: tap_d = 1'b0;
    endcase
  end
  assign pif.tick = tap_d && !pif.sel[3];

  a_t0_div8_tap: assert property (@(posedge pclk) disable iff (!presetn)
    (pif.sel == 4'h2 && pif.tick) |-> cnt_q[2:0] == 3'h7)
    else $error("divide-by-8 tap out of phase");
endmodule // t0_prescaler

// ---- t1_prescaler.sv ----
// Divider for the second timer: undivided down to divide by 16384.
// Assumes src_tick already selects system or fast peripheral clock steps.
`include "timer_params.svh"
module t1_prescaler
  import timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  presc_if.presc pif
);
  logic [`T1_PRE_W-1:0] cnt_q;
  logic [`T1_PRE_W-1:0] mask_d;

  // Divider counts source steps only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (pif.clear) begin
      cnt_q <= '0;
    end else if (pif.src_tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Select n (1..15) divides by 2^(n-1); 0 stops the timer
  always_comb begin
    mask_d = {`T1_PRE_W{1'b1}} >> (4'hF - pif.sel);
  end
  assign pif.tick = pif.src_tick && (pif.sel != 4'h0) && ((cnt_q & mask_d) == mask_d);

  a_t1_clear_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pif.clear |=> cnt_q == '0)
    else $error("second prescaler not reset by clear");
  a_t1_div_full: assert property (@(posedge pclk) disable iff (!presetn)
    (pif.sel == 4'hF && pif.tick) |-> (&cnt_q))
    else $error("divide-by-16384 tap out of phase");
endmodule // t1_prescaler

// ---- timer_top.sv ----
// Prescalers for two 8-bit timers and the first timer's counter, on APB.
// Assumes pins arrive asynchronously; the fast clock is sampled as a pin.
//
// Functional notes
// - First timer runs undivided, /8, /64, /256, /1024, from pin, or stopped.
// - Second timer clocks range undivided to /16384 of its source, plus stop.
// - Writing one to the second prescaler clear bit resets that prescaler.
// - Fast clock select set: second timer uses fast peripheral clock, else system.
// - External count pin is synchronised to the system clock on rising edges.
// - First timer overflow sets a flag; its enable sits in the mask register.
// - Upper five control bits of the first timer always read as zero.
// - Select 0 stop,1..5 taps,6 pin falling,7 pin rising edge.
// - Writing one to control bit 3 resets first prescaler; bit self-clears, reads zero.
// - Counter is read/write; after a write it counts from the next tick.
`include "timer_params.svh"
module timer_top
  import timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic t0_external_clock_pin,
  input wire logic fast_peripheral_clock,
  output logic irq,
  output logic t1_count_tick
);
  presc_if p0_if ();
  presc_if p1_if ();

  apb_state_t state_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic t1_tick_q;

  logic [2:0] t0_clock_select_q;
  logic [3:0] t1_clock_select_q;
  logic fast_clock_select_q;
  logic [7:0] t0_count_value_q;
  logic timer_flag_q;
  logic timer_mask_q;
  logic t0_clr_q;
  logic t1_clr_q;

  logic [1:0] pin_in;
  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [1:0] s3_q;
  logic [1:0] stable_q;
  logic [1:0] rise_d;
  logic [1:0] fall_d;

  logic setup_d;
  logic access_d;
  logic wr_d;
  logic rd_d;
  logic mapped_d;
  logic [31:0] rdata_d;
  logic t0_tick_d;
  logic t0_wr_count_d;
  logic t0_ovf_d;
  logic flag_clr_d;

  // Slot 0 is the count pin, slot 1 the fast peripheral clock
  assign pin_in = {fast_peripheral_clock, t0_external_clock_pin};

  // Three-stage synchronisers; a level is taken once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= pin_in[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
        end
      end

      // Filtered level; stage one is never looked at here
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stable_q[g] <= 1'b0;
        end else if (s2_q[g] == s3_q[g]) begin
          stable_q[g] <= s3_q[g];
        end
      end

      // Edge strobes from the agreed level; one pulse per transition
      assign rise_d[g] = (s2_q[g] == s3_q[g]) && s3_q[g] && !stable_q[g];
      assign fall_d[g] = (s2_q[g] == s3_q[g]) && !s3_q[g] && stable_q[g];
    end
  endgenerate

  // APB phase tracking: zero wait states, answer in the first access cycle
  assign setup_d = psel && !penable;
  assign access_d = psel && penable && pready_q;
  assign wr_d = access_d && pwrite;
  assign rd_d = access_d && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= APB_IDLE;
      pready_q <= 1'b0;
    end else begin
      case (state_q)
        APB_IDLE: begin
          if (setup_d) begin
            state_q <= APB_ACCESS;
            pready_q <= 1'b1;
          end
        end
        APB_ACCESS: begin
          state_q <= APB_IDLE;
          pready_q <= 1'b0;
        end
        default: begin
          state_q <= APB_IDLE;
          pready_q <= 1'b0;
        end
      endcase
    end
  end

  // Address decode and read-back mux
  // Clear bits are never stored, so they read zero without extra masking
  always_comb begin
    rdata_d = 32'h0000_0000;
    mapped_d = 1'b1;
    case (paddr)
      `OFS_T0_CTRL: rdata_d[2:0] = t0_clock_select_q;
      `OFS_T0_COUNT: rdata_d[7:0] = t0_count_value_q;
      `OFS_T1_CTRL_B: rdata_d[3:0] = t1_clock_select_q;
      `OFS_PLL_CS: rdata_d[`PLL_FAST_BIT] = fast_clock_select_q;
      `OFS_FLAGS: rdata_d[`FLAG_T0_OVF_BIT] = timer_flag_q;
      `OFS_MASK: rdata_d[`FLAG_T0_OVF_BIT] = timer_mask_q;
      default: mapped_d = 1'b0;
    endcase
  end

  // Read data and error are captured in setup and held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup_d && state_q == APB_IDLE) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
      pslverr_q <= !mapped_d;
    end else if (state_q == APB_ACCESS) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
  end

  // Control register writes; clear bits are not stored, only pulsed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t0_clock_select_q <= 3'h0;
      t1_clock_select_q <= 4'h0;
      fast_clock_select_q <= 1'b0;
      timer_mask_q <= 1'b0;
    end else if (wr_d) begin
      case (paddr)
        `OFS_T0_CTRL: t0_clock_select_q <= pwdata[2:0];
        `OFS_T1_CTRL_B: t1_clock_select_q <= pwdata[3:0];
        `OFS_PLL_CS: fast_clock_select_q <= pwdata[`PLL_FAST_BIT];
        `OFS_MASK: timer_mask_q <= pwdata[`FLAG_T0_OVF_BIT];
        default: ;
      endcase
    end
  end

  // One-cycle prescaler clear pulses; writing zero does nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t0_clr_q <= 1'b0;
      t1_clr_q <= 1'b0;
    end else begin
      t0_clr_q <= wr_d && paddr == `OFS_T0_CTRL && pwdata[`T0_CLR_BIT];
      t1_clr_q <= wr_d && paddr == `OFS_T1_CTRL_B && pwdata[`T1_CLR_BIT];
    end
  end

  // Prescaler hookup; the first always steps on the system clock
  assign p0_if.clear = t0_clr_q;
  assign p0_if.src_tick = 1'b1;
  assign p0_if.sel = {1'b0, t0_clock_select_q};
  assign p1_if.clear = t1_clr_q;
  assign p1_if.src_tick = fast_clock_select_q ? rise_d[1] : 1'b1;
  assign p1_if.sel = t1_clock_select_q;

  t0_prescaler u_p0 (
    .pclk(pclk),
    .presetn(presetn),
    .pif(p0_if)
  );

  t1_prescaler u_p1 (
    .pclk(pclk),
    .presetn(presetn),
    .pif(p1_if)
  );

  // First timer count source, pin edges rely on the source's spacing
  always_comb begin
    case (t0_src_t'(t0_clock_select_q))
      CS0_STOP: t0_tick_d = 1'b0;
      CS0_EXT_FALL: t0_tick_d = fall_d[0];
      CS0_EXT_RISE: t0_tick_d = rise_d[0];
      default: t0_tick_d = p0_if.tick;
    endcase
  end

  // Counter: a software write wins and the count resumes on the next tick
  assign t0_wr_count_d = wr_d && paddr == `OFS_T0_COUNT;
  assign t0_ovf_d = t0_tick_d && !t0_wr_count_d && t0_count_value_q == `T0_COUNT_MAX;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t0_count_value_q <= `BYTE_RESET;
    end else if (t0_wr_count_d) begin
      t0_count_value_q <= pwdata[7:0];
    end else if (t0_tick_d) begin
      t0_count_value_q <= t0_count_value_q + 8'h01;
    end
  end

  // Sticky overflow flag; a read clears only what it returned, so a new set wins
  assign flag_clr_d = rd_d && paddr == `OFS_FLAGS && prdata_q[`FLAG_T0_OVF_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_flag_q <= 1'b0;
    end else if (t0_ovf_d) begin
      timer_flag_q <= 1'b1;
    end else if (flag_clr_d) begin
      timer_flag_q <= 1'b0;
    end
  end

  // Registered outputs: interrupt level and second timer count tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
      t1_tick_q <= 1'b0;
    end else begin
      irq_q <= timer_flag_q && timer_mask_q;
      t1_tick_q <= p1_if.tick;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign t1_count_tick = t1_tick_q;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Read-back and prescaler clear pulses
  a_ctrl_upper_zero: assert property (
    (setup_d && !pwrite && paddr == `OFS_T0_CTRL) |=> prdata[7:3] == 5'h00)
    else $error("reserved or clear bits of first control read nonzero");
  a_t0_clr_pulse: assert property (
    (wr_d && paddr == `OFS_T0_CTRL && pwdata[`T0_CLR_BIT]) |=> t0_clr_q ##1 !t0_clr_q)
    else $error("first prescaler clear not a single pulse");
  a_t1_clr_pulse: assert property (
    (wr_d && paddr == `OFS_T1_CTRL_B && pwdata[`T1_CLR_BIT]) |=> t1_clr_q)
    else $error("second prescaler clear missing");
  a_t1_clr_reads_zero: assert property (
    (setup_d && !pwrite && paddr == `OFS_T1_CTRL_B) |=> prdata[`T1_CLR_BIT] == 1'b0)
    else $error("second prescaler clear bit read back set");

  // Counter steps, wrap and stop
  a_count_write: assert property (
    t0_wr_count_d |=> t0_count_value_q == $past(pwdata[7:0]))
    else $error("counter write not taken");
  a_count_wrap: assert property (
    t0_ovf_d |=> t0_count_value_q == 8'h00 && timer_flag_q)
    else $error("wrap did not clear count and set flag");
  a_flag_set_at_wrap: assert property (
    $rose(timer_flag_q) |-> $past(t0_count_value_q) == `T0_COUNT_MAX)
    else $error("flag set away from the wrap");
  a_count_stop: assert property (
    (t0_clock_select_q == 3'h0 && !t0_wr_count_d) |=> $stable(t0_count_value_q))
    else $error("stopped counter moved");
  a_div1_count: assert property (
    (t0_clock_select_q == 3'h1 && !t0_wr_count_d)
      |=> t0_count_value_q == $past(t0_count_value_q) + 8'h01)
    else $error("undivided select did not step the counter");

  // Pin path; the far side must keep two clocks between transitions
  a_pin_rise_count: assert property (
    (t0_clock_select_q == 3'h7 && rise_d[0] && !t0_wr_count_d)
      |=> t0_count_value_q == $past(t0_count_value_q) + 8'h01)
    else $error("pin rising edge not counted");
  a_pin_rise_only: assert property (
    (t0_clock_select_q == 3'h7 && !rise_d[0] && !t0_wr_count_d)
      |=> $stable(t0_count_value_q))
    else $error("rising pin select counted without a rising edge");
  a_pin_fall_count: assert property (
    (t0_clock_select_q == 3'h6 && fall_d[0] && !t0_wr_count_d)
      |=> t0_count_value_q == $past(t0_count_value_q) + 8'h01)
    else $error("pin falling edge not counted");
  a_pin_sync_delay: assert property (
    $rose(t0_external_clock_pin) ##1 t0_external_clock_pin [*3]
      |-> rise_d[0] || stable_q[0])
    else $error("pin edge not seen after three cycles");

  // Second timer source choice
  a_fast_source: assert property (
    (fast_clock_select_q && !rise_d[1]) |-> !p1_if.tick)
    else $error("second timer ticked without fast clock edge");
  a_sys_source: assert property (
    !fast_clock_select_q |-> p1_if.src_tick)
    else $error("second prescaler starved on the system clock");

  // Flag and interrupt level
  a_irq_level: assert property (
    (timer_flag_q && timer_mask_q) |=> irq)
    else $error("interrupt not raised for unmasked flag");
  a_irq_masked: assert property (
    !(timer_flag_q && timer_mask_q) |=> !irq)
    else $error("interrupt raised without unmasked flag");
  a_flag_read_clear: assert property (
    (flag_clr_d && !t0_ovf_d) |=> !timer_flag_q)
    else $error("flag not cleared by its read");

  c_overflow_irq: cover property (t0_ovf_d && timer_mask_q ##[1:3] irq);
  c_pin_fall_count: cover property (t0_clock_select_q == 3'h6 && fall_d[0]);
  c_fast_tick: cover property (fast_clock_select_q && p1_if.tick);
  c_flag_read_clear: cover property (flag_clr_d);
  c_t1_restart: cover property (t1_clr_q && t1_clock_select_q == 4'hF);
endmodule // timer_top

// ---- count_source.sv ----
// Pulse source standing in for whatever drives a timer count pin.
// Assumes a pull-down on the pin, so it rests low between bursts.
module count_source (
  input wire logic pclk,
  output logic pin
);
  timeunit 1ns;
  timeprecision 100ps;

  // Pin idles low outside bursts
  initial pin = 1'b0;

  // Whole periods only, so a burst ends low; half below one is raised to one
  task automatic burst(input int n, input int half);
    int h;
    h = (half < 1) ? 1 : half;
    repeat (2 * n) begin
      repeat (h) @(posedge pclk);
      pin <= ~pin;
    end
  endtask
endmodule // count_source

// ---- timer_prescalers_and_counter0_tb.sv ----
// Self-checking bench for the timer prescalers and first counter.
// Assumes zero-wait APB, a registered overflow interrupt and pin sources.
`include "timer_params.svh"
module timer_prescalers_and_counter0_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, t1_count_tick, last_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv, c1;
  wire t0_pin;
  wire fast_clk;
  int error_cnt, checks_done, tick_cnt, ts;
  int t0_win[6] = '{1, 1, 8, 64, 256, 1024};
  int t1_sel[6] = '{0, 1, 2, 4, 8, 15};
  int t1_win[6] = '{40, 1, 2, 8, 128, 16384};

  timer_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .t0_external_clock_pin(t0_pin), .fast_peripheral_clock(fast_clk),
    .irq(irq), .t1_count_tick(t1_count_tick));
  count_source u_pin (.pclk(pclk), .pin(t0_pin));
  count_source u_fast (.pclk(pclk), .pin(fast_clk));

  // 25 MHz clock
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  // Count second-timer steps away from the rising edge to avoid races
  always @(negedge pclk) if (t1_count_tick === 1'b1) tick_cnt++;

  task check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer plus an idle edge, so psel never toggles twice in a step
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer however long; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task rd(input logic [7:0] a);
    xfer(a, 1'b0, 32'h0);
  endtask

  task results;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Run takes about 50k cycles; a hang is cut off well after that
  initial begin
    repeat (90000) @(posedge pclk);
    error_cnt++;
    $display("watchdog expired");
    results;
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // All registers clear after reset; unmapped place refused
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i));
      check(rv, 32'h0);
    end
    wr(8'h18, 32'hFF);
    check(32'(last_err), 32'h1);
    rd(8'h18);
    check(rv, 32'h0);
    check(32'(last_err), 32'h1);
    wr(`OFS_T0_CTRL, 32'hFF);
    rd(`OFS_T0_CTRL);
    check(rv, 32'h7);
    check(32'(last_err), 32'h0);
    $display("test registers done");
    // Selects 0 to 5 of the first timer: steps seen in a window of four tap periods
    for (int s = 0; s < 6; s++) begin
      wr(`OFS_T0_CTRL, 32'(s));
      rd(`OFS_T0_COUNT);
      c1 = rv;
      repeat (4 * t0_win[s] - 3) @(posedge pclk);
      rd(`OFS_T0_COUNT);
      check(32'(8'(rv[7:0] - c1[7:0])), (s == 0) ? 32'h0 : 32'h4);
    end
    // Second clear restarts the /1024 phase, so no step lands in the window
    wr(`OFS_T0_CTRL, 32'hD);
    repeat (600) @(posedge pclk);
    wr(`OFS_T0_CTRL, 32'hD);
    rd(`OFS_T0_COUNT);
    c1 = rv;
    repeat (900) @(posedge pclk);
    rd(`OFS_T0_COUNT);
    check(rv, c1);
    $display("test first prescaler done");
    // Write, wrap, flag and interrupt, unmasked then masked
    wr(`OFS_T0_CTRL, 32'h0);
    wr(`OFS_T0_COUNT, 32'hFD);
    rd(`OFS_T0_COUNT);
    check(rv, 32'hFD);
    for (int m = 1; m >= 0; m--) begin
      wr(`OFS_MASK, 32'(m));
      wr(`OFS_T0_COUNT, 32'hFE);
      wr(`OFS_T0_CTRL, 32'h1);
      wr(`OFS_T0_CTRL, 32'h0);
      check(32'(irq), 32'(m));
      rd(`OFS_T0_COUNT);
      check(rv, 32'h1);
      rd(`OFS_FLAGS);
      check(rv, 32'h1);
      repeat (2) @(posedge pclk);
      check(32'(irq), 32'h0);
      rd(`OFS_FLAGS);
      check(rv, 32'h0);
    end
    $display("test overflow done");
    // Pin edges counted on rising then falling select
    for (int s = 7; s >= 6; s--) begin
      wr(`OFS_T0_CTRL, 32'(s));
      wr(`OFS_T0_COUNT, 32'h0);
      u_pin.burst(5, 4);
      repeat (8) @(posedge pclk);
      rd(`OFS_T0_COUNT);
      check(rv, 32'h5);
    end
    wr(`OFS_T0_CTRL, 32'h0);
    $display("test pin done");
    // Second timer on the system clock: one step per window, none when stopped
    for (int k = 0; k < 6; k++) begin
      wr(`OFS_T1_CTRL_B, 32'(t1_sel[k]));
      repeat (4) @(posedge pclk);
      ts = tick_cnt;
      repeat (t1_win[k]) @(posedge pclk);
      check(32'(tick_cnt - ts), (k == 0) ? 32'h0 : 32'h1);
    end
    wr(`OFS_T1_CTRL_B, 32'h4F);
    repeat (10000) @(posedge pclk);
    wr(`OFS_T1_CTRL_B, 32'h4F);
    ts = tick_cnt;
    repeat (16000) @(posedge pclk);
    check(32'(tick_cnt - ts), 32'h0);
    rd(`OFS_T1_CTRL_B);
    check(rv, 32'hF);
    // Fast source selected: idle fast clock gives no steps, running one does
    wr(`OFS_PLL_CS, 32'h4);
    rd(`OFS_PLL_CS);
    check(rv, 32'h4);
    wr(`OFS_T1_CTRL_B, 32'h1);
    repeat (4) @(posedge pclk);
    ts = tick_cnt;
    repeat (40) @(posedge pclk);
    check(32'(tick_cnt - ts), 32'h0);
    fork
      u_fast.burst(12, 4);
      begin
        repeat (20) @(posedge pclk);
        ts = tick_cnt;
        repeat (64) @(posedge pclk);
        check(32'(tick_cnt - ts), 32'h8);
      end
    join
    $display("test second prescaler done");
    results;
  end
endmodule // timer_prescalers_and_counter0_tb
